// File: design/log_page_content_builder.sv
// Purpose: serves firmware slot, changed namespace and effects log pages
// Assumes: firmware fills tables over the register port; host reads dwords
// Notes:   one dword answer per request, one cycle after the request
//
// Behaviour
// - byte zero bits 2:0 give running slot
// - bits 6:4 give next-reset slot, zero none
// - seven revision fields bytes 8-63, rest reserved
// - invalid or unsupported slot revision reads zero
// - namespace list holds up to 1024 entries
// - each completed list read (page close) restarts change accumulation
// - overflow marks first entry, rest zero
// - effects page 4096 bytes, upper half reserved
// - admin entry at opcode times four
// - io entry at 1024 plus opcode times four
// - io entries follow selected command set
// - entries describe widest possible command effect
// - unsupported opcode entry reads all zero
// - bits 18:16 restriction code, reserved codes excluded
`timescale 1ns/1ps
`default_nettype none

module log_page_content_builder
    import log_page_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire ns_event_s   ns_change,
    input  wire log_req_s    log_in,
    output logic      [31:0] log_data,
    output logic             log_valid
);

    typedef struct packed {
        logic [2:0]        running_slot;
        logic [2:0]        next_slot;
        logic [2:0]        command_set_select;
        logic [2:0]        io_set;
        logic [6:0]        slot_valid;
        logic [13:0][31:0] rev;
        logic [10:0]       ns_count;
        logic              ns_overflow;
        logic [31:0]       rdata;
        logic [31:0]       log_data;
        logic              log_valid;
    } state_s;

    state_s st;
    state_s next_st;

    logic [31:0] effect_mem [0:511];
    logic [31:0] ns_mem     [0:1023];

    ////////////////////////////////////////////////////////////////////////
    // entry clean-up: software may write junk into reserved fields
    function automatic logic [31:0] clean_entry(input logic [31:0] raw);
        logic [31:0] e;
        e = raw & EFF_KEEP_MASK;
        if (e[18:16] > SUB_MAX_CODE) begin
            e[18:16] = 3'h0;
        end
        if (!e[0]) begin
            e = 32'h00000000;
        end
        return e;
    endfunction

    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // log page dword builder, combinational from held state
    logic [31:0] page_word;
    logic [3:0]  rev_sel;
    logic [2:0]  rev_slot;
    logic [8:0]  eff_sel;

    always_comb begin
        rev_sel   = 4'(log_in.index - FW_REV_FIRST);
        rev_slot  = rev_sel[3:1];
        eff_sel   = log_in.index[8:0];
        page_word = 32'h00000000;
        unique case (log_in.page)
            PAGE_FIRMWARE: begin
                if (log_in.index == 10'h000) begin
                    page_word = {25'h0, st.next_slot, 1'b0,
                                 st.running_slot};
                end else if (log_in.index >= FW_REV_FIRST &&
                             log_in.index <= FW_REV_LAST) begin
                    if (st.slot_valid[rev_slot]) begin
                        page_word = st.rev[rev_sel];
                    end
                end
            end
            PAGE_NS_LIST: begin
                if (st.ns_overflow) begin
                    page_word = (log_in.index == 10'h000) ? NS_OVERFLOW
                                                          : 32'h00000000;
                end else if ({1'b0, log_in.index} < st.ns_count) begin
                    page_word = ns_mem[log_in.index];
                end
            end
            PAGE_EFFECTS: begin
                if (log_in.index <= EFF_LAST) begin
                    if (log_in.index < EFF_IO_FIRST) begin
                        page_word = clean_entry(effect_mem[eff_sel]);
                    end else if (st.command_set_select == st.io_set) begin
                        page_word = clean_entry(effect_mem[eff_sel]);
                    end
                end
            end
            PAGE_NONE: page_word = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // register read mux
    logic [31:0] reg_word;
    logic [3:0]  reg_rev;

    always_comb begin
        reg_rev  = reg_addr[5:2] - 4'h0;
        reg_word = 32'h00000000;                          // unmapped reads zero
        if (reg_addr == REG_CTRL) begin
            reg_word = {17'h0, st.io_set, 1'b0, st.command_set_select, 1'b0, st.next_slot,
                        1'b0, st.running_slot};
        end else if (reg_addr == REG_SLOT_VALID) begin
            reg_word = {25'h0, st.slot_valid};
        end else if (reg_addr == REG_STATUS) begin
            reg_word = {19'h0, st.ns_overflow, 1'b0, st.ns_count};
        end else if (in_range(reg_addr, REG_REV_BASE, REG_REV_LAST)) begin
            reg_word = st.rev[reg_rev];
        end else if (in_range(reg_addr, REG_EFFECT_BASE, REG_EFFECT_LAST)) begin
            reg_word = effect_mem[reg_addr[10:2]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: register writes, namespace tracking, answers
    logic ns_clear;

    always_comb begin
        next_st  = st;
        ns_clear = log_in.done && log_in.page == PAGE_NS_LIST;
        if (reg_wr && reg_addr == REG_CTRL) begin
            next_st.running_slot       = reg_wdata[CTRL_RUN_LSB +: 3];
            next_st.next_slot          = reg_wdata[CTRL_NEXT_LSB +: 3];
            next_st.command_set_select = reg_wdata[CTRL_CMD_SET_LSB +: 3];
            next_st.io_set             = reg_wdata[CTRL_IOS_LSB +: 3];
        end
        if (reg_wr && reg_addr == REG_SLOT_VALID) begin
            next_st.slot_valid = reg_wdata[6:0];
        end
        if (reg_wr && in_range(reg_addr, REG_REV_BASE, REG_REV_LAST)) begin
            next_st.rev[reg_rev] = reg_wdata;
        end
        // a completed list read restarts tracking; an event in the
        // same cycle lands as the first entry of the new list
        if (ns_clear) begin
            next_st.ns_count    = 11'h000;
            next_st.ns_overflow = 1'b0;
        end
        if (ns_change.valid) begin
            if (ns_clear || st.ns_count < NS_LIST_MAX) begin
                next_st.ns_count = ns_clear ? 11'h001 : 11'(st.ns_count + 11'h001);
            end else begin
                next_st.ns_overflow = 1'b1;
            end
        end
        next_st.rdata     = reg_rd ? reg_word : 32'h00000000;
        next_st.log_data  = log_in.req ? page_word : 32'h00000000;
        next_st.log_valid = log_in.req;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // table storage; arrays are kept out of the state copy for area
    logic [9:0] ns_wr_at;

    assign ns_wr_at = ns_clear ? 10'h000 : st.ns_count[9:0];

    always_ff @(posedge clk_sys) begin
        if (reg_wr && in_range(reg_addr, REG_EFFECT_BASE, REG_EFFECT_LAST)) begin
            effect_mem[reg_addr[10:2]] <= reg_wdata;
        end
        if (ns_change.valid && (ns_clear || st.ns_count < NS_LIST_MAX)) begin
            ns_mem[ns_wr_at] <= ns_change.id;
        end
    end

    assign reg_rdata = st.rdata;
    assign log_data  = st.log_data;
    assign log_valid = st.log_valid;

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_RUN_SLOT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.req && log_in.page == PAGE_FIRMWARE && log_in.index == 10'h000
        |=> log_data[2:0] == $past(st.running_slot))
        else $error("running slot field wrong");

    AST_NEXT_SLOT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.req && log_in.page == PAGE_FIRMWARE && log_in.index == 10'h000
        |=> log_data[6:4] == $past(st.next_slot) && log_data[31:7] == 25'h0
            && !log_data[3])
        else $error("next slot field or reserved bits wrong");

    AST_FW_RSVD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.req && log_in.page == PAGE_FIRMWARE
        && (log_in.index == 10'h001 || log_in.index > FW_REV_LAST)
        |=> log_valid && log_data == 32'h00000000)
        else $error("reserved firmware bytes not zero");

    AST_REV_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.req && log_in.page == PAGE_FIRMWARE && log_in.index == 10'h002
        && !st.slot_valid[0] |=> log_data == 32'h00000000)
        else $error("invalid slot revision not zero");

    AST_NS_OVF: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.req && log_in.page == PAGE_NS_LIST && st.ns_overflow
        |=> log_data == ($past(log_in.index) == 10'h000 ? NS_OVERFLOW : 32'h0))
        else $error("overflow list layout wrong");

    AST_NS_CLEAR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.done && log_in.page == PAGE_NS_LIST && !ns_change.valid
        |=> st.ns_count == 11'h000 && !st.ns_overflow)
        else $error("list read did not restart tracking");

    AST_NS_CAP: assert property (@(posedge clk_sys) disable iff (!reset_n)
        st.ns_count == NS_LIST_MAX && ns_change.valid && !log_in.done
        |=> st.ns_overflow && st.ns_count == NS_LIST_MAX)
        else $error("list grew past its capacity");

    AST_EFF_RSVD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.req && log_in.page == PAGE_EFFECTS && log_in.index > EFF_LAST
        |=> log_data == 32'h00000000)
        else $error("reserved effects half not zero");

    AST_UNSUPP: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_valid && !log_data[0] && $past(log_in.page) == PAGE_EFFECTS
        |-> log_data == 32'h00000000)
        else $error("unsupported entry carries fields");

    AST_RESTRICT_CODE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_valid && $past(log_in.page) == PAGE_EFFECTS
        |-> log_data[18:16] <= SUB_MAX_CODE && log_data[31:19] == 13'h0)
        else $error("restriction code reserved");

    AST_IO_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.req && log_in.page == PAGE_EFFECTS && log_in.index >= EFF_IO_FIRST
        && st.command_set_select != st.io_set |=> log_data == 32'h00000000)
        else $error("io entries shown for other command set");

    // an event in the restart cycle must open the new list, not vanish
    AST_NS_SET_WINS: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.done && log_in.page == PAGE_NS_LIST && ns_change.valid
        |=> st.ns_count == 11'h001 && !st.ns_overflow)
        else $error("event beside list restart was lost");

    AST_NS_GROW: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ns_change.valid && !log_in.done && st.ns_count < NS_LIST_MAX
        |=> st.ns_count == $past(st.ns_count) + 11'h001)
        else $error("list count did not follow an event");

    AST_NS_TAIL_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_in.req && log_in.page == PAGE_NS_LIST && !st.ns_overflow
        && {1'b0, log_in.index} >= st.ns_count |=> log_data == 32'h00000000)
        else $error("list entry past the count not zero");

    AST_ENTRY_RSVD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        log_valid && $past(log_in.page) == PAGE_EFFECTS |-> log_data[15:5] == 11'h000)
        else $error("effects entry reserved bits not zero");

    AST_LOG_IDLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !log_in.req |=> !log_valid && log_data == 32'h00000000)
        else $error("log answer outside its cycle");

    AST_REG_IDLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside its cycle");

endmodule // log_page_content_builder

`default_nettype wire

// File: design/log_page_pkg.sv
// Purpose: constants and carriers for the log page content builder
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes:   all control state resets to zero
`default_nettype none

package log_page_pkg;

    // register byte offsets
    localparam logic [15:0] REG_CTRL        = 16'h0000;
    localparam logic [15:0] REG_SLOT_VALID  = 16'h0004;
    localparam logic [15:0] REG_STATUS      = 16'h0008;
    localparam logic [15:0] REG_REV_BASE    = 16'h0040;
    localparam logic [15:0] REG_REV_LAST    = 16'h0074;
    localparam logic [15:0] REG_EFFECT_BASE = 16'h1000;
    localparam logic [15:0] REG_EFFECT_LAST = 16'h17fc;

    // control register field positions
    localparam int CTRL_RUN_LSB     = 0;
    localparam int CTRL_NEXT_LSB    = 4;
    localparam int CTRL_CMD_SET_LSB = 8;
    localparam int CTRL_IOS_LSB     = 12;

    // log page geometry in dwords
    localparam logic [9:0] FW_REV_FIRST  = 10'h002;
    localparam logic [9:0] FW_REV_LAST   = 10'h00f;
    localparam logic [9:0] EFF_IO_FIRST  = 10'h100;
    localparam logic [9:0] EFF_LAST      = 10'h1ff;
    localparam logic [10:0] NS_LIST_MAX  = 11'h400;
    localparam logic [31:0] NS_OVERFLOW  = 32'hffffffff;

    // effects entry fields
    localparam logic [31:0] EFF_KEEP_MASK = 32'h0007001f;
    localparam logic [2:0]  SUB_MAX_CODE  = 3'h2;

    typedef enum logic [1:0] {
        PAGE_FIRMWARE  = 2'b00,
        PAGE_NS_LIST   = 2'b01,
        PAGE_EFFECTS   = 2'b10,
        PAGE_NONE      = 2'b11
    } log_page_e;

    typedef struct packed {
        logic       req;
        log_page_e  page;
        logic [9:0] index;
        logic       done;
    } log_req_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] id;
    } ns_event_s;

endpackage

`default_nettype wire

// File: testbench/host_log_model.sv
// Purpose: host side model that fetches log page dwords
// Assumes: one outstanding request at a time
// Notes:   released read request fields show inverted values; a page close leaves page set
`timescale 1ns/1ps
`default_nettype none

module host_log_model
    import log_page_pkg::*;
(
    input  wire logic        clk_sys,
    output var log_req_s     log_in,
    input  wire logic [31:0] log_data,
    input  wire logic        log_valid
);
    initial log_in = '0;

    ////////////////////////////////////////////////////////////
    // waits for each answer before the next request, so commands never overlap
    task automatic read_dword(input log_page_e pg, input logic [9:0] idx,
                              output logic [31:0] d, output logic v);
        @(posedge clk_sys);
        log_in.req   <= 1'b1;
        log_in.page  <= pg;
        log_in.index <= idx;
        @(posedge clk_sys);
        log_in.req   <= 1'b0;
        log_in.page  <= log_page_e'(~pg);
        log_in.index <= ~idx;
        #1;
        v = log_valid;
        d = log_data;
    endtask

    // closes a page read; the bench re-reads after every change it makes
    task automatic end_page(input log_page_e pg);
        @(posedge clk_sys);
        log_in.done <= 1'b1;
        log_in.page <= pg;
        @(posedge clk_sys);
        log_in.done <= 1'b0;
    endtask
endmodule // host_log_model

`default_nettype wire

// File: testbench/log_page_content_builder_tb.sv
// Purpose: self-checking bench for the log page content builder
// Assumes: register port and host model drive just after the rising edge
// Notes:   effects table is written before any effects read
`timescale 1ns/1ps
`default_nettype none

module log_page_content_builder_tb
    import log_page_pkg::*;
;
    logic        clk_sys, reset_n, reg_wr, reg_rd, log_valid, v;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, log_data, seen, lo, hi;
    ns_event_s   ns_change;
    log_req_s    log_in;
    int          failures, checked;
    typedef struct {log_page_e pg; logic [9:0] idx; logic [31:0] exp;} row_s;
    // ordinary reads after setup: page, dword index, expected dword
    row_s rows [13] = '{
        '{PAGE_FIRMWARE, 10'h000, 32'h00000053}, '{PAGE_FIRMWARE, 10'h001, 32'h0},
        '{PAGE_FIRMWARE, 10'h010, 32'h0}, '{PAGE_FIRMWARE, 10'h07f, 32'h0},
        '{PAGE_EFFECTS, 10'h000, 32'h0000001f}, '{PAGE_EFFECTS, 10'h001, 32'h0},
        '{PAGE_EFFECTS, 10'h0ff, 32'h00020013}, '{PAGE_EFFECTS, 10'h100, 32'h00010003},
        '{PAGE_EFFECTS, 10'h101, 32'h00000005}, '{PAGE_EFFECTS, 10'h1ff, 32'h00000019},
        '{PAGE_EFFECTS, 10'h200, 32'h0}, '{PAGE_EFFECTS, 10'h3ff, 32'h0},
        '{PAGE_NONE, 10'h000, 32'h0}};

    log_page_content_builder log_page_content_builder_i (.clk_sys, .reset_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ns_change, .log_in, .log_data, .log_valid);
    host_log_model host_log_model_i (.clk_sys, .log_in, .log_data, .log_valid);

    ////////////////////////////////////////////////////////////
    // compare, count and report
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic fetch(input log_page_e pg, input logic [9:0] idx, input logic [31:0] e);
        host_log_model_i.read_dword(pg, idx, seen, v);
        check({31'h0, v}, 32'h1);
        check(seen, e);
    endtask
    // back-to-back change events, ids counting up from first
    task automatic ns_events(input int n, input logic [31:0] first);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            ns_change <= '{1'b1, first + 32'(i)};
        end
        @(posedge clk_sys);
        ns_change <= '{1'b0, 32'h0};
    endtask
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk_sys);
        failures++;
        summarize();
    end
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0;
        reg_wdata = 32'h0;
        ns_change = '0;
        failures = 0;
        checked = 0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        reg_read(REG_CTRL, seen);
        check(seen, 32'h0);
        fetch(PAGE_FIRMWARE, 10'h000, 32'h0);
        // running 3, next 5, command set 2 selected and described
        reg_write(REG_CTRL, 32'h00002253);
        reg_write(REG_SLOT_VALID, 32'h00000005);
        reg_write(REG_EFFECT_BASE, 32'hffffffff);
        reg_write(REG_EFFECT_BASE + 16'h0004, 32'h0001001e);
        reg_write(REG_EFFECT_BASE + 16'h03fc, 32'h00020013);
        reg_write(REG_EFFECT_BASE + 16'h0400, 32'h00010003);
        reg_write(REG_EFFECT_BASE + 16'h0404, 32'h00000005);
        reg_write(REG_EFFECT_BASE + 16'h07fc, 32'h00040019);
        for (int k = 1; k <= 7; k++) begin
            reg_write(REG_REV_BASE + 16'(8 * (k - 1)), 32'h312e3000 + 32'(k));
            reg_write(REG_REV_BASE + 16'(8 * (k - 1) + 4), 32'h20202000 + 32'(k));
        end
        foreach (rows[i]) begin
            fetch(rows[i].pg, rows[i].idx, rows[i].exp);
        end
        // only slots 1 and 3 hold a valid revision
        for (int k = 1; k <= 7; k++) begin
            lo = (k == 1 || k == 3) ? 32'h312e3000 + 32'(k) : 32'h0;
            hi = (k == 1 || k == 3) ? 32'h20202000 + 32'(k) : 32'h0;
            fetch(PAGE_FIRMWARE, 10'(2 * k), lo);
            fetch(PAGE_FIRMWARE, 10'(2 * k + 1), hi);
        end
        // slot 1 withdrawn while its revision words still hold text
        reg_write(REG_SLOT_VALID, 32'h00000002);
        fetch(PAGE_FIRMWARE, 10'h002, 32'h0);
        fetch(PAGE_FIRMWARE, 10'h004, 32'h312e3002);
        // reserved bits 3 and 7 set, selected set differs from the table's set
        reg_write(REG_CTRL, 32'h000021bb);
        fetch(PAGE_FIRMWARE, 10'h000, 32'h00000033);
        fetch(PAGE_EFFECTS, 10'h100, 32'h0);
        reg_write(REG_CTRL, 32'h00001103);
        fetch(PAGE_FIRMWARE, 10'h000, 32'h00000003);
        fetch(PAGE_EFFECTS, 10'h100, 32'h00010003);
        reg_write(16'h0100, 32'hffffffff);
        reg_read(16'h0100, seen);
        check(seen, 32'h0);
        // change list, restart on page close, then overflow
        ns_events(2, 32'h5);
        reg_read(REG_STATUS, seen);
        check(seen, 32'h2);
        fetch(PAGE_NS_LIST, 10'h000, 32'h5);
        fetch(PAGE_NS_LIST, 10'h001, 32'h6);
        host_log_model_i.end_page(PAGE_NS_LIST);
        ns_events(1, 32'h7);
        fetch(PAGE_NS_LIST, 10'h000, 32'h7);
        fetch(PAGE_NS_LIST, 10'h001, 32'h0);
        reg_read(REG_STATUS, seen);
        check(seen, 32'h1);
        host_log_model_i.end_page(PAGE_NS_LIST);
        ns_events(1025, 32'h100);
        reg_read(REG_STATUS, seen);
        check(seen, 32'h00001400);
        fetch(PAGE_NS_LIST, 10'h000, NS_OVERFLOW);
        fetch(PAGE_NS_LIST, 10'h001, 32'h0);
        fetch(PAGE_NS_LIST, 10'h3ff, 32'h0);
        // list close and event in one cycle: the event opens the new list
        fork
            host_log_model_i.end_page(PAGE_NS_LIST);
            ns_events(1, 32'h9);
        join
        reg_read(REG_STATUS, seen);
        check(seen, 32'h1);
        fetch(PAGE_NS_LIST, 10'h000, 32'h9);
        fetch(PAGE_NS_LIST, 10'h001, 32'h0);
        // mid-run reset clears control, slot mask and change tracking
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        reg_read(REG_CTRL, seen);
        check(seen, 32'h0);
        reg_read(REG_STATUS, seen);
        check(seen, 32'h0);
        fetch(PAGE_FIRMWARE, 10'h002, 32'h0);
        fetch(PAGE_NS_LIST, 10'h000, 32'h0);
        summarize();
    end
endmodule // log_page_content_builder_tb

`default_nettype wire
